// ### upper_address_pin_mux_pkg.sv
/*
  Package for the upper address pin multiplexer: pin count, function
  codes and reset values.
  Assumes a single core clock domain; no software register bus.
*/
`default_nettype none
package upper_address_pin_mux_pkg;
  localparam int unsigned PIN_COUNT = 4;

  // Function chosen by the strap at reset release
  typedef enum logic {
    FUNC_GPIO,
    FUNC_ADDR
  } pin_func_t;

  localparam logic [PIN_COUNT-1:0] PINS_ZERO   = 4'h0;
  localparam logic                 KEEPER_RST  = 1'b1;
  localparam logic                 STRAP_HIGH  = 1'b1;
endpackage
`default_nettype wire

// ### pin_keeper.sv
/*
  Per-pin bus holder: remembers the drive_out level of each pin while its
  drive_oe was set, and drives that level back weakly while the pin floats.
  Assumes pad levels are synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_keeper
  import upper_address_pin_mux_pkg::*;
#(
  parameter int unsigned WIDTH = PIN_COUNT
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Pad side
  input  wire logic [WIDTH-1:0] pad_in,
  input  wire logic [WIDTH-1:0] drive_oe,
  input  wire logic [WIDTH-1:0] drive_out,
  input  wire logic             keeper_en,
  // Keeper drive
  output logic      [WIDTH-1:0] hold_out,
  output logic      [WIDTH-1:0] hold_oe
);
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] hold_oe_d;

  // Track the driven level; while floating the held level is reinforced
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_d[i]   = drive_oe[i] ? drive_out[i] : level_q[i];
      hold_oe_d[i] = keeper_en & ~drive_oe[i];          // see (RULE_04)
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      level_q <= PINS_ZERO;
    end else begin
      level_q <= level_d;
    end
  end

  // Enable is not registered: a registered copy fed by the pad enable it
  // feeds would toggle every cycle; the top registers the merged enable
  assign hold_out = level_q;
  assign hold_oe  = hold_oe_d;
endmodule // pin_keeper
`default_nettype wire

// ### upper_address_pin_mux.sv
/*
  Pin multiplexer for the four uppermost parallel-port address pins:
  general-purpose I/O or upper external memory address, chosen by a strap
  caught at reset release, with a software-controlled keeper.
  Assumes all inputs synchronous to core_clk; pad wiring resolves oe/out.
*/
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// (RULE_01) Strap low at reset routes the pins to general-purpose I/O lines 3..0.
// (RULE_02) Strap high at reset routes the pins to memory address bits 21..18.
// (RULE_03) The function is fixed on the low-to-high edge of reset.
// (RULE_04) While the pins float, an enabled keeper holds the last driven level.
// (RULE_05) Keepers are enabled out of reset and software can toggle them.
// (RULE_06) In I/O mode all four lines are inputs after reset.
// (RULE_07) In address mode the outputs float throughout reset.
// (RULE_08) In address mode the outputs are enabled after reset and drive zero.
// (RULE_09) The pins float while bus hold mode is active.
// (RULE_10) The pins float in off mode (test reset 0, emulation 0 high, off pin low).
// (RULE_11) The pins float while reset is held low.
// (RULE_12) Strap stays stable in reset; the latched selection lasts until next reset.
module upper_address_pin_mux
  import upper_address_pin_mux_pkg::*;
#(
  parameter int unsigned WIDTH = PIN_COUNT
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Strap and mode pins
  input  wire logic             function_strap_pin,
  input  wire logic             bus_hold_req,
  input  wire logic             test_resetn,
  input  wire logic             emulation_pin_zero,
  input  wire logic             emulation_off_pin,
  // Keeper control bit of ext_bus_control_reg
  input  wire logic             keeper_enable_wr,
  input  wire logic             keeper_enable_val,
  // General-purpose I/O core side
  input  wire logic [WIDTH-1:0] gpio_dir_out,
  input  wire logic [WIDTH-1:0] gpio_out_val,
  output logic      [WIDTH-1:0] parallel_gp_io_lines,
  // Memory interface core side
  input  wire logic             addr_drive_en,
  input  wire logic [WIDTH-1:0] ext_mem_upper_address,
  // Pads
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe,
  // Status
  output logic                  addr_mode,
  output logic                  keeper_enabled
);
  logic             rst_seen_q;
  logic             rst_seen_d;
  logic             addr_mode_d;
  logic             keeper_d;
  logic [WIDTH-1:0] pad_out_d;
  logic [WIDTH-1:0] pad_oe_d;
  logic [WIDTH-1:0] gpio_in_d;
  logic [WIDTH-1:0] hold_out;
  logic [WIDTH-1:0] hold_oe;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] dir_d;
  logic             off_mode;
  logic             float_all;

  // Off mode and hold both force the pads to float
  assign off_mode  = ~test_resetn & emulation_pin_zero & ~emulation_off_pin; // see (RULE_10)
  assign float_all = off_mode | bus_hold_req;                                // see (RULE_09)

  // Strap catch: the first clocked cycle after release samples the strap
  always_comb begin
    rst_seen_d  = 1'b1;
    addr_mode_d = addr_mode;
    if (!rst_seen_q) begin
      addr_mode_d = (function_strap_pin == STRAP_HIGH);  // see (RULE_03) (RULE_12)
    end
  end

  // Keeper enable, written by software
  always_comb begin
    keeper_d = keeper_enabled;
    if (keeper_enable_wr) begin
      keeper_d = keeper_enable_val;                      // see (RULE_05)
    end
  end

  // Pad routing per selected function
  always_comb begin
    dir_d     = gpio_dir_out;
    gpio_in_d = pad_in;
    if (!rst_seen_q) begin
      dir_d = PINS_ZERO;                                 // see (RULE_06)
    end
    if (addr_mode) begin
      pad_out_d = ext_mem_upper_address;                 // see (RULE_02)
      pad_oe_d  = {WIDTH{addr_drive_en}};                // see (RULE_08)
    end else begin
      pad_out_d = gpio_out_val;                          // see (RULE_01)
      pad_oe_d  = dir_q;
    end
    if (float_all || !rst_seen_q) begin
      pad_oe_d = PINS_ZERO;
    end
  end

  // Registers; reset floats every pad and clears the driven level
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rst_seen_q           <= 1'b0;
      addr_mode            <= 1'b0;
      keeper_enabled       <= KEEPER_RST;                // see (RULE_05)
      dir_q                <= PINS_ZERO;
      pad_out              <= PINS_ZERO;
      pad_oe               <= PINS_ZERO;                 // see (RULE_07) (RULE_11)
      parallel_gp_io_lines <= PINS_ZERO;
    end else begin
      rst_seen_q           <= rst_seen_d;
      addr_mode            <= addr_mode_d;
      keeper_enabled       <= keeper_d;
      dir_q                <= dir_d;
      pad_out              <= hold_oe_mux(pad_out_d, pad_oe_d);
      pad_oe               <= pad_oe_d | (hold_oe & ~pad_oe_d);
      parallel_gp_io_lines <= gpio_in_d;
    end
  end

  // When nobody drives, the keeper level takes the output
  function automatic logic [WIDTH-1:0] hold_oe_mux(input logic [WIDTH-1:0] v,
                                                   input logic [WIDTH-1:0] oe);
    hold_oe_mux = (v & oe) | (hold_out & ~oe);           // see (RULE_04)
  endfunction

  pin_keeper #(.WIDTH(WIDTH)) u_keeper (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .pad_in    (pad_in),
    .drive_oe  (pad_oe_d),                               // Function drive only
    .drive_out (pad_out_d),
    .keeper_en (keeper_enabled & rst_seen_q),
    .hold_out  (hold_out),
    .hold_oe   (hold_oe)
  );
endmodule // upper_address_pin_mux
`default_nettype wire

// ### upper_address_pin_mux_chk.sv
/* Checker for the upper address pin mux ports.
   Assumes one clock domain; bound from the bench. */
`timescale 1ns/10ps
`default_nettype none
module upper_address_pin_mux_chk (
  // Clock, reset and controls
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       function_strap_pin,
  input wire logic       bus_hold_req,
  input wire logic       test_resetn,
  input wire logic       emulation_pin_zero,
  input wire logic       emulation_off_pin,
  input wire logic       keeper_enable_wr,
  input wire logic       keeper_enable_val,
  input wire logic       addr_drive_en,
  input wire logic [3:0] ext_mem_upper_address,
  // Watched outputs
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic       addr_mode,
  input wire logic       keeper_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  rst_float_a:
    assert property (disable iff (1'b0) !resetn |=> !pad_oe) else $error("drive in reset");
  keep_rst_a:
    assert property (disable iff (1'b0) !resetn |=> keeper_enabled) else $error("keeper reset");
  strap_latch_a:
    assert property ($rose(resetn) |=> addr_mode == $past(function_strap_pin)) else $error("strap");
  mode_hold_a:
    assert property (resetn [*3] |-> $stable(addr_mode)) else $error("mode moved");
  early_float_a:
    assert property ($rose(resetn) |=> !pad_oe) else $error("early drive");
  keep_wr_a:
    assert property (keeper_enable_wr |=> keeper_enabled == $past(keeper_enable_val))
      else $error("keeper write");
  addr_drv_a:
    assert property (resetn [*3] ##0 addr_mode && addr_drive_en && !bus_hold_req &&
      !(!test_resetn && emulation_pin_zero && !emulation_off_pin) |=>
      pad_oe == 4'hf && pad_out == $past(ext_mem_upper_address)) else $error("address");
  hold_float_a:
    assert property (bus_hold_req && !keeper_enabled |=> !pad_oe) else $error("hold drive");
  // Main scenarios reached
  cover property ($rose(resetn) ##1 addr_mode);
  cover property (bus_hold_req && keeper_enabled);
  cover property (bus_hold_req && !keeper_enabled);
endmodule // upper_address_pin_mux_chk
`default_nettype wire

// ### board_model.sv
/* Board model on the four upper pads.
   Assumes no pull on the lines. */
`timescale 1ns/10ps
`default_nettype none
module board_model (
  // Clock
  input  wire logic       core_clk,
  // Pads
  input  wire logic [3:0] pad_out,
  input  wire logic [3:0] pad_oe,
  input  wire logic       ext_en,
  input  wire logic [3:0] ext_val,
  output logic      [3:0] pad_in
);
  logic [3:0] last_q = 4'h0;
  // Board beats the weak keeper; a free line flips so stale data shows
  assign pad_in = ext_en ? ext_val : pad_oe & pad_out | ~pad_oe & ~last_q;
  always_ff @(posedge core_clk) last_q <= pad_in;
endmodule // board_model
`default_nettype wire

// ### upper_address_pin_mux_tb.sv
/* Bench for the upper address pin mux.
   Assumes the board model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module upper_address_pin_mux_tb;
  logic       core_clk = 0, resetn = 0, function_strap_pin = 0, bus_hold_req = 0, ext_en = 0;
  logic       test_resetn = 1, emulation_pin_zero = 0, emulation_off_pin = 1, addr_drive_en = 0;
  logic       keeper_enable_wr = 0, keeper_enable_val = 0, addr_mode, keeper_enabled;
  logic [3:0] gpio_dir_out = '0, gpio_out_val = '0, ext_mem_upper_address = '0, ext_val = '0;
  logic [3:0] parallel_gp_io_lines, pad_in, pad_out, pad_oe;
  int         miscompares = 0, checks_done = 0;
  always #5 core_clk = ~core_clk;
  upper_address_pin_mux i_dut (.*);
  board_model i_brd (.*);
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Drive just after the edge so nothing races the sampling
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Reset with a strap, then flip it to prove it is ignored
  task automatic do_reset(input logic s);
    resetn = 0;
    function_strap_pin = s;
    step(8);
    chk(pad_oe, 4'h0);
    chk(keeper_enabled, 1'b1);
    resetn = 1;
    step(2);
    chk(addr_mode, s);
    function_strap_pin = ~s;
  endtask
  task automatic t_addr;
    do_reset(1'b1);
    addr_drive_en = 1;
    step(1);
    chk(pad_oe, 4'hf);
    chk(pad_out, 4'h0);
    ext_mem_upper_address = 4'ha;
    step(1);
    chk(pad_out, 4'ha);
    bus_hold_req = 1;
    step(3);
    chk(pad_in, 4'ha);
    step(1);
    chk(pad_in, 4'ha);
    keeper_enable_wr = 1;
    step(1);
    keeper_enable_wr = 0;
    step(1);
    chk(pad_oe, 4'h0);
    bus_hold_req = 0;
    test_resetn = 0;
    emulation_pin_zero = 1;
    emulation_off_pin = 0;
    step(2);
    chk(pad_oe, 4'h0);
    test_resetn = 1;
    step(2);
    chk(pad_oe, 4'hf);
  endtask
  task automatic t_gpio;
    do_reset(1'b0);
    ext_en = 1;
    ext_val = 4'h5;
    step(2);
    chk(parallel_gp_io_lines, 4'h5);
    ext_en = 0;
    gpio_dir_out = 4'hf;
    gpio_out_val = 4'h3;
    step(2);
    chk(pad_out, 4'h3);
    step(1);
    chk(parallel_gp_io_lines, 4'h3);
  endtask
  initial begin
    t_addr;
    t_gpio;
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    report_and_stop;
  end
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
endmodule // upper_address_pin_mux_tb
bind upper_address_pin_mux upper_address_pin_mux_chk i_chk (.*);
`default_nettype wire
